// >>> eic_pkg.sv
// shared constants and types of the external bus idle cycle inserter
package eic_pkg;
    // register map
    localparam logic [31:0] CTRL_ADDR    = 32'h0000_0000;
    localparam logic [15:0] CTRL_RESET   = 16'hFF00;
    localparam logic [15:0] RSV_MASK     = 16'h8000;
    localparam int          RSV_BIT      = 15;
    localparam int          WR_EN_BIT    = 14;
    localparam int          AC_EN_BIT    = 13;
    localparam int          RW_EN_BIT    = 12;
    localparam int          CNTB_LSB     = 10;
    localparam int          CNTA_LSB     = 8;
    localparam int          SEL_LSB      = 0;
    localparam int          AREA_N       = 8;
    // bus encodings
    localparam logic [2:0]  HSIZE_WORD   = 3'h2;
    localparam logic        HRESP_OKAY   = 1'b0;
    // idle counting
    localparam logic [2:0]  GAP_MAX      = 3'h4;
    localparam logic [2:0]  IDLE_NONE    = 3'h0;
    localparam logic [2:0]  CNTB_IDLE_01 = 3'h2;
    localparam logic [2:0]  CNTB_IDLE_10 = 3'h3;
    localparam logic [2:0]  CNTB_IDLE_11 = 3'h4;
    // sequencer states
    typedef enum logic [1:0] {
        EIC_FREE,
        EIC_IDLE,
        EIC_ACTIVE
    } eic_state_t;
endpackage

// >>> eic_cfg_if.sv
// configuration fields passed from the register block to the sequencer
`timescale 1ns/1ns
`default_nettype none
interface eic_cfg_if;
    logic       wrEn;
    logic       acEn;
    logic       rwEn;
    logic [1:0] cntA;
    logic [1:0] cntB;
    logic [7:0] areaSel;
    modport regs (output wrEn, acEn, rwEn, cntA, cntB, areaSel);
    modport core (input wrEn, acEn, rwEn, cntA, cntB, areaSel);
endinterface
`default_nettype wire

// >>> eic_ahb_regs.sv
// ahb-lite slave holding the idle control register
`timescale 1ns/1ns
`default_nettype none
module eic_ahb_regs (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    eic_cfg_if.regs          cfg
);
    logic [15:0] ctrl;
    logic [15:0] next_ctrl;
    logic        wrPend;
    logic        next_wrPend;
    logic [31:0] next_rdata;
    logic        take;
    logic        hit;

    // address phase decode, word accesses only
    assign take = hsel && hready && htrans[1];
    assign hit  = (haddr[31:2] == eic_pkg::CTRL_ADDR[31:2]) && (hsize == eic_pkg::HSIZE_WORD);

    // write in data phase, read data with write forwarding
    always_comb begin
        next_ctrl   = ctrl;
        next_wrPend = take && hwrite && hit;
        next_rdata  = hrdata;
        if (wrPend) begin
            next_ctrl = hwdata[15:0] | eic_pkg::RSV_MASK;
        end
        if (take && !hwrite) begin
            next_rdata = hit ? {16'h0000, next_ctrl | eic_pkg::RSV_MASK} : 32'h0000_0000;
        end
    end

    // register stage, zero wait states, always okay
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl      <= eic_pkg::CTRL_RESET;
            wrPend    <= 1'b0;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= eic_pkg::HRESP_OKAY;
        end else begin
            ctrl      <= next_ctrl;
            wrPend    <= next_wrPend;
            hrdata    <= next_rdata;
            hreadyout <= 1'b1;
            hresp     <= eic_pkg::HRESP_OKAY;
        end
    end

    // field outputs
    assign cfg.wrEn    = ctrl[eic_pkg::WR_EN_BIT];
    assign cfg.acEn    = ctrl[eic_pkg::AC_EN_BIT];
    assign cfg.rwEn    = ctrl[eic_pkg::RW_EN_BIT];
    assign cfg.cntB    = ctrl[eic_pkg::CNTB_LSB +: 2];
    assign cfg.cntA    = ctrl[eic_pkg::CNTA_LSB +: 2];
    assign cfg.areaSel = ctrl[eic_pkg::SEL_LSB +: eic_pkg::AREA_N];

    rsv_read_a : assert property (@(posedge clk) disable iff (!rstn)
        (take && !hwrite && hit) |=> hrdata[eic_pkg::RSV_BIT])
        else $error("reserved bit read back as zero");
endmodule
`default_nettype wire

// >>> eic_idle_cnt.sv
// down counter timing the inserted idle cycles
`timescale 1ns/1ns
`default_nettype none
module eic_idle_cnt (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       load,
    input  wire logic [2:0] loadVal,
    output logic            done
);
    logic [2:0] count;
    logic [2:0] next_count;

    // load, then count down to zero
    always_comb begin
        next_count = count;
        if (load) begin
            next_count = loadVal;
        end else if (count != 3'h0) begin
            next_count = count - 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            count <= 3'h0;
        end else begin
            count <= next_count;
        end
    end

    // last idle cycle in progress
    assign done = (count == 3'h1);
endmodule
`default_nettype wire

// >>> eic_idle_inserter.sv
// Function
// - reserved top bit reads one; software writes one there
// - write followed by read gets idle cycles only when its enable is set
// - reads to different areas get idle cycles only when enabled
// - read followed by write gets idle cycles only when enabled
// - count A codes 00..11 give one to four idle cycles
// - count B code 00 gives none, code 01 gives two
// - count A serves all conditions; write-then-read always uses A
// - count B only for area-change reads and read-then-write
// - each of eight areas has a select bit choosing A or B
//
// Local design decisions: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module eic_idle_inserter (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        cycReq,
    input  wire logic        cycWrite,
    input  wire logic [2:0]  cycArea,
    input  wire logic        cycEnd,
    output logic             cycGrant,
    output logic             idleInsert
);
    eic_cfg_if cfg ();

    // idle count A: code plus one
    function automatic logic [2:0] decA(input logic [1:0] code);
        decA = {1'b0, code} + 3'h1;
    endfunction

    // idle count B: none, two, three, four
    function automatic logic [2:0] decB(input logic [1:0] code);
        unique case (code)
            2'b00: decB = eic_pkg::IDLE_NONE;
            2'b01: decB = eic_pkg::CNTB_IDLE_01;
            2'b10: decB = eic_pkg::CNTB_IDLE_10;
            2'b11: decB = eic_pkg::CNTB_IDLE_11;
        endcase
    endfunction

    eic_pkg::eic_state_t state;
    eic_pkg::eic_state_t next_state;
    logic       lastValid;
    logic       next_lastValid;
    logic       lastWrite;
    logic       next_lastWrite;
    logic [2:0] lastArea;
    logic [2:0] next_lastArea;
    logic [2:0] gap;
    logic [2:0] next_gap;
    logic       next_cycGrant;
    logic       next_idleInsert;
    logic       cntLoad;
    logic       cntDone;
    logic       selB;
    logic [2:0] pickCnt;
    logic [2:0] needRaw;
    logic [2:0] needLeft;
    logic       startReq;
    logic       isWrRd;
    logic       isRdRd;
    logic       isRdWr;

    // register block on the bus
    eic_ahb_regs uRegs (
        .clk       (clk),
        .rstn      (rstn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .cfg       (cfg)
    );

    // idle cycle timer
    eic_idle_cnt uCnt (
        .clk     (clk),
        .rstn    (rstn),
        .load    (cntLoad),
        .loadVal (needLeft),
        .done    (cntDone)
    );

    // classify the pending cycle against the one before
    assign startReq = (state == eic_pkg::EIC_FREE) && cycReq;
    assign isWrRd   = lastValid && lastWrite && !cycWrite;
    assign isRdRd   = lastValid && !lastWrite && !cycWrite && (cycArea != lastArea);
    assign isRdWr   = lastValid && !lastWrite && cycWrite;

    // idle count needed for the pending cycle
    always_comb begin
        selB    = cfg.areaSel[lastArea];
        pickCnt = selB ? decB(cfg.cntB) : decA(cfg.cntA);
        needRaw = eic_pkg::IDLE_NONE;
        if (isWrRd) begin
            if (cfg.wrEn) begin
                needRaw = decA(cfg.cntA);
            end
        end else if (isRdRd) begin
            if (cfg.acEn) begin
                needRaw = pickCnt;
            end
        end else if (isRdWr) begin
            if (cfg.rwEn) begin
                needRaw = pickCnt;
            end
        end
        // idle cycles already elapsed count toward the need
        needLeft = (needRaw > gap) ? needRaw - gap : eic_pkg::IDLE_NONE;
    end

    assign cntLoad = startReq && (needLeft != eic_pkg::IDLE_NONE);

    // sequencer: grant now, or insert idles first
    always_comb begin
        next_state      = state;
        next_lastValid  = lastValid;
        next_lastWrite  = lastWrite;
        next_lastArea   = lastArea;
        next_gap        = gap;
        next_cycGrant   = 1'b0;
        next_idleInsert = 1'b0;
        unique case (state)
            eic_pkg::EIC_FREE: begin
                if (cycReq) begin
                    if (needLeft == eic_pkg::IDLE_NONE) begin
                        next_cycGrant = 1'b1;
                        next_state    = eic_pkg::EIC_ACTIVE;
                    end else begin
                        next_idleInsert = 1'b1;
                        next_state      = eic_pkg::EIC_IDLE;
                    end
                end else if (gap != eic_pkg::GAP_MAX) begin
                    next_gap = gap + 3'h1;
                end
            end
            eic_pkg::EIC_IDLE: begin
                if (cntDone) begin
                    next_cycGrant = 1'b1;
                    next_state    = eic_pkg::EIC_ACTIVE;
                end else begin
                    next_idleInsert = 1'b1;
                end
            end
            eic_pkg::EIC_ACTIVE: begin
                if (cycEnd) begin
                    next_gap   = 3'h0;
                    next_state = eic_pkg::EIC_FREE;
                end
            end
        endcase
        // remember the cycle as it is granted
        if (next_cycGrant) begin
            next_lastValid = 1'b1;
            next_lastWrite = cycWrite;
            next_lastArea  = cycArea;
        end
    end

    // sequencer registers
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state      <= eic_pkg::EIC_FREE;
            lastValid  <= 1'b0;
            lastWrite  <= 1'b0;
            lastArea   <= 3'h0;
            gap        <= 3'h0;
            cycGrant   <= 1'b0;
            idleInsert <= 1'b0;
        end else begin
            state      <= next_state;
            lastValid  <= next_lastValid;
            lastWrite  <= next_lastWrite;
            lastArea   <= next_lastArea;
            gap        <= next_gap;
            cycGrant   <= next_cycGrant;
            idleInsert <= next_idleInsert;
        end
    end

    // a request with no idle need is granted at the next edge
    no_idle_grant_a : assert property (@(posedge clk) disable iff (!rstn)
        (startReq && needLeft == 3'h0) |=> cycGrant)
        else $error("grant late without idle need");

    // four idles: grant after four idle cycles, none sooner
    four_idle_grant_a : assert property (@(posedge clk) disable iff (!rstn)
        (startReq && needLeft == 3'h4) |=> (!cycGrant && idleInsert) [*4] ##1 cycGrant)
        else $error("four idle cycles not kept");

    // write then read, enable off: nothing inserted
    wr_rd_off_a : assert property (@(posedge clk) disable iff (!rstn)
        (startReq && isWrRd && !cfg.wrEn) |-> needRaw == 3'h0)
        else $error("idle inserted with write-read off");

    // write then read always takes count A, even when area selects B
    wr_rd_count_a : assert property (@(posedge clk) disable iff (!rstn)
        (startReq && isWrRd && cfg.wrEn && cfg.cntA == 2'b00) |-> needRaw == 3'h1)
        else $error("write-read count not from field A");

    // area change read, selected A
    rd_area_a : assert property (@(posedge clk) disable iff (!rstn)
        (startReq && isRdRd && cfg.acEn && !selB && cfg.cntA == 2'b11) |-> needRaw == 3'h4)
        else $error("area change read count wrong");

    // area change read disabled
    rd_area_off_a : assert property (@(posedge clk) disable iff (!rstn)
        (startReq && isRdRd && !cfg.acEn) |-> needRaw == 3'h0)
        else $error("idle inserted with area change off");

    // read then write through count B code 01
    rd_wr_b_a : assert property (@(posedge clk) disable iff (!rstn)
        (startReq && isRdWr && cfg.rwEn && selB && cfg.cntB == 2'b01) |-> needRaw == 3'h2)
        else $error("read-write count B wrong");

    // count B code 00 inserts nothing
    b_none_a : assert property (@(posedge clk) disable iff (!rstn)
        (startReq && (isRdWr || isRdRd) && selB && cfg.cntB == 2'b00) |-> needRaw == 3'h0)
        else $error("count B zero code inserted idles");

    // count B code 10 gives three idles
    b_three_a : assert property (@(posedge clk) disable iff (!rstn)
        (startReq && isRdWr && cfg.rwEn && selB && cfg.cntB == 2'b10) |-> needRaw == 3'h3)
        else $error("count B code 10 wrong");

    // read then write disabled
    rd_wr_off_a : assert property (@(posedge clk) disable iff (!rstn)
        (startReq && isRdWr && !cfg.rwEn) |-> needRaw == 3'h0)
        else $error("idle inserted with read-write off");

    // one idle: a single idle cycle, then the grant
    one_idle_grant_a : assert property (@(posedge clk) disable iff (!rstn)
        (startReq && needLeft == 3'h1) |=> (idleInsert && !cycGrant) ##1 (cycGrant && !idleInsert))
        else $error("one idle cycle not kept");

    // two idles, then the grant
    two_idle_grant_a : assert property (@(posedge clk) disable iff (!rstn)
        (startReq && needLeft == 3'h2) |=> (idleInsert && !cycGrant) [*2] ##1 (cycGrant && !idleInsert))
        else $error("two idle cycles not kept");

    // three idles, then the grant
    three_idle_grant_a : assert property (@(posedge clk) disable iff (!rstn)
        (startReq && needLeft == 3'h3) |=> (idleInsert && !cycGrant) [*3] ##1 (cycGrant && !idleInsert))
        else $error("three idle cycles not kept");

    // grant is a single-cycle pulse
    grant_pulse_a : assert property (@(posedge clk) disable iff (!rstn)
        cycGrant |=> !cycGrant)
        else $error("grant held longer than one cycle");

    // no grant and no idle while a granted cycle runs
    busy_quiet_a : assert property (@(posedge clk) disable iff (!rstn)
        (state == eic_pkg::EIC_ACTIVE && !cycEnd) |=> (!cycGrant && !idleInsert))
        else $error("grant or idle during external cycle");

    // the first cycle after reset never waits
    first_cycle_a : assert property (@(posedge clk) disable iff (!rstn)
        (startReq && !lastValid) |-> needRaw == 3'h0)
        else $error("idle need without previous cycle");

    // write then read, count A code 11 gives four
    wr_rd_four_a : assert property (@(posedge clk) disable iff (!rstn)
        (startReq && isWrRd && cfg.wrEn && cfg.cntA == 2'b11) |-> needRaw == 3'h4)
        else $error("write-read count A code 11 wrong");

    // write then read, count A code 10 gives three
    wr_rd_three_a : assert property (@(posedge clk) disable iff (!rstn)
        (startReq && isWrRd && cfg.wrEn && cfg.cntA == 2'b10) |-> needRaw == 3'h3)
        else $error("write-read count A code 10 wrong");

    // reads to the same area need no idles
    same_area_a : assert property (@(posedge clk) disable iff (!rstn)
        (startReq && lastValid && !lastWrite && !cycWrite && cycArea == lastArea) |-> needRaw == 3'h0)
        else $error("idle need on same area reads");

    // write after write needs no idles
    wr_wr_none_a : assert property (@(posedge clk) disable iff (!rstn)
        (startReq && lastValid && lastWrite && cycWrite) |-> needRaw == 3'h0)
        else $error("idle need on write after write");

    // area change read through count B code 10
    rd_area_b_a : assert property (@(posedge clk) disable iff (!rstn)
        (startReq && isRdRd && cfg.acEn && selB && cfg.cntB == 2'b10) |-> needRaw == 3'h3)
        else $error("area change read count B wrong");

    // read then write, select zero takes count A
    rw_sel_zero_a : assert property (@(posedge clk) disable iff (!rstn)
        (startReq && isRdWr && cfg.rwEn && !selB && cfg.cntA == 2'b01) |-> needRaw == 3'h2)
        else $error("read-write count A wrong");
endmodule
`default_nettype wire

// >>> eic_ext_mem.sv
// far-side model: external device finishing each granted cycle
`timescale 1ns/1ns
`default_nettype none
module eic_ext_mem (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic cycGrant,
    output logic      cycEnd
);
    logic       busy;
    logic [1:0] left;
    logic [1:0] len;
    // cycle length rotates 1..3 so both prompt and slow ends occur
    always_ff @(posedge clk) begin
        if (!rstn) begin
            busy   <= 1'b0;
            left   <= 2'h0;
            len    <= 2'h1;
            cycEnd <= 1'b0;
        end else begin
            cycEnd <= 1'b0;
            if (cycGrant) begin
                busy <= 1'b1;
                left <= len;
                len  <= (len == 2'h3) ? 2'h1 : len + 2'h1;
            end else if (busy) begin
                if (left == 2'h0) begin
                    busy   <= 1'b0;
                    cycEnd <= 1'b1; // one-cycle end pulse
                end else begin
                    left <= left - 2'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb_external_bus_idle_cycle_inserter.sv
// testbench of the idle cycle inserter: register access and gap counts
`timescale 1ns/1ns
`default_nettype none
module tb_external_bus_idle_cycle_inserter;
    logic        clk;
    logic        rstn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        cycReq;
    logic        cycWrite;
    logic [2:0]  cycArea;
    logic        cycEnd;
    logic        cycGrant;
    logic        idleInsert;
    int          fails;
    int          n_tests;
    logic        pv;
    logic        pw;
    logic [2:0]  pa;
    logic [31:0] rd;
    logic [15:0] cfgs [9] = '{16'hFF00, 16'hF000, 16'hF100, 16'hF200, 16'hF4FF,
                             16'hF8FF, 16'hF0FF, 16'h8000, 16'hB6AA};
    logic        sw [7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    logic [2:0]  sa [7] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h2};

    eic_idle_inserter i_eic_idle_inserter (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cycReq(cycReq), .cycWrite(cycWrite),
        .cycArea(cycArea), .cycEnd(cycEnd), .cycGrant(cycGrant), .idleInsert(idleInsert));
    eic_ext_mem i_eic_ext_mem (.clk(clk), .rstn(rstn), .cycGrant(cycGrant), .cycEnd(cycEnd));

    // clock generation
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t reg got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input logic [4:0] got, input logic [4:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t count got %0d exp %0d", $time, got, exp);
        end
    endtask

    // one ahb-lite single transfer, entered just after a rising edge
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        hsize  <= eic_pkg::HSIZE_WORD;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wr ? d : 32'h0;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    // idle count expected for the next cycle
    function automatic logic [4:0] exp_n(input logic w, input logic [2:0] a, input logic [15:0] r);
        logic [2:0] na;
        logic [2:0] nb;
        logic [2:0] ns;
        na = {1'b0, r[eic_pkg::CNTA_LSB +: 2]} + 3'h1;
        nb = (r[eic_pkg::CNTB_LSB +: 2] == 2'h0) ? 3'h0 : {1'b0, r[eic_pkg::CNTB_LSB +: 2]} + 3'h1;
        ns = r[eic_pkg::SEL_LSB + pa] ? nb : na;
        if (!pv) return 5'h0;
        if (pw && !w) return r[eic_pkg::WR_EN_BIT] ? {2'h0, na} : 5'h0;
        if (!pw && !w && pa != a) return r[eic_pkg::AC_EN_BIT] ? {2'h0, ns} : 5'h0;
        if (!pw && w) return r[eic_pkg::RW_EN_BIT] ? {2'h0, ns} : 5'h0;
        return 5'h0;
    endfunction

    // one external cycle: request, count idles, await end
    task automatic cyc(input logic w, input logic [2:0] a, input logic [15:0] r);
        logic [4:0] e;
        logic [4:0] ni;
        logic [4:0] lat;
        e = exp_n(w, a, r);
        ni = 5'h0;
        lat = 5'h0;
        cycReq   <= 1'b1;
        cycWrite <= w;
        cycArea  <= a;
        do begin
            @(posedge clk);
            lat++;
            if (idleInsert === 1'b1) ni++;
        end while (cycGrant !== 1'b1 && lat < 5'd20);
        cycReq <= 1'b0;
        chk_cnt(ni, e);
        chk_cnt(lat, e + 5'h2);
        do @(posedge clk); while (cycEnd !== 1'b1);
        pv = 1'b1;
        pw = w;
        pa = a;
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        close_out();
    end

    // main sequence
    initial begin
        fails = 0; n_tests = 0; pv = 1'b0; pw = 1'b0; pa = 3'h0;
        rstn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
        hsize = 3'h0; hwdata = 32'h0; cycReq = 1'b0; cycWrite = 1'b0; cycArea = 3'h0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        ahb(1'b0, eic_pkg::CTRL_ADDR, 32'h0, rd);
        chk_reg(rd, 32'h0000_FF00);
        chk_reg({30'h0, hreadyout, hresp}, 32'h0000_0002);
        ahb(1'b1, eic_pkg::CTRL_ADDR, 32'h0000_8000, rd);
        ahb(1'b0, eic_pkg::CTRL_ADDR, 32'h0, rd);
        chk_reg(rd, 32'h0000_8000);
        ahb(1'b1, 32'h0000_0040, 32'h0000_7FFF, rd);
        ahb(1'b0, 32'h0000_0040, 32'h0, rd);
        chk_reg(rd, 32'h0);
        ahb(1'b0, eic_pkg::CTRL_ADDR, 32'h0, rd);
        chk_reg(rd, 32'h0000_8000);
        $display("register test done");
        for (int i = 0; i < 9; i++) begin
            ahb(1'b1, eic_pkg::CTRL_ADDR, {16'h0, cfgs[i]}, rd);
            ahb(1'b0, eic_pkg::CTRL_ADDR, 32'h0, rd);
            chk_reg(rd, {16'h0, cfgs[i]});
            pv = 1'b0;
            for (int j = 0; j < 7; j++) cyc(sw[j], sa[j], cfgs[i]);
            $display("gap test %0d done", i);
        end
        close_out();
    end
endmodule
`default_nettype wire
